//--- sbac_cfg.svh
// Constants for the system bus arbitration control block
`ifndef SBAC_CFG_SVH
`define SBAC_CFG_SVH

`define SBAC_BPM_W        6
`define SBAC_BPM_PROBE_READY     4
`define SBAC_BPM_PROBE_REQUEST     5
`define SBAC_AGENT_ID_W   2
`define SBAC_AGENT_ZERO   2'h0
`define SBAC_AGENT_ONE    2'h1
`define SBAC_BSEL_W       2
`define SBAC_CFG_DLY      4'h3
`define SBAC_BUS_INIT_SIGNAL_PULSE  4'h2
`define SBAC_CNT_ZERO     4'h0
`define SBAC_CNT_ONE      4'h1

`endif

//--- sbac_pkg.sv
// Types for the system bus arbitration control block
`include "sbac_cfg.svh"

package sbac_pkg;

    // Arbitration states for the request side
    typedef enum logic [1:0] {
        SBAC_IDLE,
        SBAC_REQ,
        SBAC_OWN
    } sbac_arb_t;

    // Configuration captured at power-on
    typedef struct packed {
        logic                          bus_init_signal_drv_en;
        logic                          bus_init_signal_obs_en;
        logic [`SBAC_AGENT_ID_W-1:0]   agent_id;
        logic [`SBAC_BSEL_W-1:0]       bus_clock_select;
    } sbac_cfg_t;

endpackage

//--- sbac_cfg_capture.sv
// Power-on configuration capture for the arbitration block
`timescale 1ns/1ps
`default_nettype none
`include "sbac_cfg.svh"

module sbac_cfg_capture (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             nrst,
    // Straps sampled during configuration
    input  wire sbac_pkg::sbac_cfg_t straps,
    // Held configuration
    output logic                  valid,
    output sbac_pkg::sbac_cfg_t   cfg
);

    logic [3:0]          cnt;
    logic [3:0]          next_cnt;
    logic                next_valid;
    sbac_pkg::sbac_cfg_t next_cfg;

    // Sample once after release, then freeze until the next reset
    always_comb begin
        next_cnt   = cnt;
        next_valid = valid;
        next_cfg   = cfg;
        if (!valid) begin
            if (cnt == `SBAC_CFG_DLY) begin
                next_valid = 1'b1;
                next_cfg   = straps;
            end else begin
                next_cnt = cnt + `SBAC_CNT_ONE;
            end
        end
    end

    // Registers take constants under reset; straps are caught after release
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cnt   <= `SBAC_CNT_ZERO;
            valid <= 1'b0;
            cfg   <= '0;
        end else begin
            cnt   <= next_cnt;
            valid <= next_valid;
            cfg   <= next_cfg;
        end
    end

    // Held configuration never moves once valid
    property p_cfg_held;
        @(posedge clk) disable iff (!nrst)
        $past(valid) |-> $stable(cfg) && valid;
    endproperty
    a_cfg_held: assert property (p_cfg_held) else $error("config changed");

endmodule
`default_nettype wire

//--- sbac_arbiter.sv
// System bus arbitration and control for one symmetric agent
//----------------------------------------------------------------------
// How it works
// - Drive bus init on fatal error, if enabled
// - Observed bus init resets lock and arbitration
// - In-order queue survives bus init untouched
// - After bus init, re-arbitrate and finish queues
// - Assert block-next-request when unable to accept
// - Owner issues nothing while stall signalled
// - Priority request stops new non-locked requests
// - Request the bus on bus request out
// - Sample request pin at power-on: low for agent zero, high for agent one
// - Drive five of the six breakpoint monitor pins
// - One monitor pin is probe ready output
// - One monitor pin is probe request input
// - Clock select fixes one common bus frequency
//----------------------------------------------------------------------
`timescale 1ns/1ps
`default_nettype none
`include "sbac_cfg.svh"

module sbac_arbiter #(
    parameter int BPM_W = `SBAC_BPM_W
) (
    // Clock and reset
    input  wire logic              CORE_CLK,
    input  wire logic              NRST,
    // Power-on straps
    input  wire logic              BUS_INIT_SIGNAL_DRV_STRAP,
    input  wire logic              BUS_INIT_SIGNAL_OBS_STRAP,
    input  wire logic [1:0]        BUS_CLOCK_SELECT_STRAP,
    // Bus init pin, open drain, active low
    input  wire logic              BUS_INIT_SIGNAL_N_IN,
    output logic                   BUS_INIT_SIGNAL_N_OUT,
    output logic                   BUS_INIT_SIGNAL_N_OE,
    // Block next request pin, open drain, active low
    input  wire logic              BLOCK_NEXT_REQUEST_SIGNAL_N_IN,
    output logic                   BLOCK_NEXT_REQUEST_SIGNAL_N_OUT,
    output logic                   BLOCK_NEXT_REQUEST_SIGNAL_N_OE,
    // Priority agent request, active low
    input  wire logic              PRIORITY_AGENT_REQUEST_N,
    // Bus request out, two-way for the power-on sample
    input  wire logic              BUS_REQUEST_OUT_N_IN,
    output logic                   BUS_REQUEST_OUT_N_OUT,
    output logic                   BUS_REQUEST_OUT_N_OE,
    // Breakpoint monitor pins, active low
    input  wire logic [BPM_W-1:0]  BREAKPOINT_MONITOR_PINS_N_IN,
    output logic [BPM_W-1:0]       BREAKPOINT_MONITOR_PINS_N_OUT,
    output logic [BPM_W-1:0]       BREAKPOINT_MONITOR_PINS_N_OE,
    // Core side
    input  wire logic              FATAL_BUS_ERROR,
    input  wire logic              CANNOT_ACCEPT,
    input  wire logic              TXN_PENDING,
    input  wire logic              TXN_LOCKED,
    input  wire logic              BUS_OWNER,
    input  wire logic [3:0]        MONITOR_STATUS,
    input  wire logic              DEBUG_READY,
    output logic                   ISSUE_ALLOWED,
    output logic                   BUS_INIT_SEEN,
    output logic                   PROBE_REQUEST,
    output logic                   CFG_VALID,
    output logic [1:0]             AGENT_ID,
    output logic [1:0]             BUS_CLOCK_SELECT
);

    // Monitor pin positions are fixed, so refuse any other group width
    if (BPM_W != `SBAC_BPM_W) begin : g_bpm_w_check
        $error("BPM_W must be six");
    end

    sbac_pkg::sbac_cfg_t straps;
    sbac_pkg::sbac_cfg_t cfg;
    logic                cfg_valid;

    // Bus request pin reads low for agent zero
    assign straps.bus_init_signal_drv_en     = BUS_INIT_SIGNAL_DRV_STRAP;
    assign straps.bus_init_signal_obs_en     = BUS_INIT_SIGNAL_OBS_STRAP;
    assign straps.agent_id         = BUS_REQUEST_OUT_N_IN ? `SBAC_AGENT_ONE
                                                          : `SBAC_AGENT_ZERO;
    assign straps.bus_clock_select = BUS_CLOCK_SELECT_STRAP;

    sbac_cfg_capture u_cfg (
        .clk    (CORE_CLK),
        .nrst   (NRST),
        .straps (straps),
        .valid  (cfg_valid),
        .cfg    (cfg)
    );

    //------------------------------------------------------------------
    // Arbitration state
    //------------------------------------------------------------------
    sbac_pkg::sbac_arb_t state;
    sbac_pkg::sbac_arb_t next_state;
    logic                bus_init_signal_drive;
    logic                next_bus_init_signal_drive;
    logic [3:0]          bus_init_signal_cnt;
    logic [3:0]          next_bus_init_signal_cnt;
    logic                bus_init_signal_seen;
    logic                next_bus_init_signal_seen;
    logic                lock_active;
    logic                next_lock_active;
    logic                bnr_drive;
    logic                next_bnr_drive;
    logic [BPM_W-1:0]    bpm_out;
    logic [BPM_W-1:0]    next_bpm_out;
    logic                probe_request;
    logic                next_probe_request;
    logic                bus_init_signal_obs;
    logic                stalled;
    logic                prio;

    // Observed levels, all pins active low
    assign bus_init_signal_obs = cfg_valid && cfg.bus_init_signal_obs_en && !BUS_INIT_SIGNAL_N_IN;
    assign stalled   = !BLOCK_NEXT_REQUEST_SIGNAL_N_IN;
    assign prio      = !PRIORITY_AGENT_REQUEST_N;

    // Next values for arbitration, stall and bus init drive
    always_comb begin
        next_state       = state;
        next_lock_active = lock_active;
        next_bus_init_signal_drive = 1'b0;
        next_bus_init_signal_cnt   = bus_init_signal_cnt;
        next_bus_init_signal_seen  = bus_init_signal_obs;
        next_bnr_drive   = CANNOT_ACCEPT;
        // Fatal error pulses bus init for a fixed span
        if (bus_init_signal_cnt != `SBAC_CNT_ZERO) begin
            next_bus_init_signal_cnt   = bus_init_signal_cnt - `SBAC_CNT_ONE;
            next_bus_init_signal_drive = 1'b1;
        end else if (cfg_valid && cfg.bus_init_signal_drv_en && FATAL_BUS_ERROR) begin
            next_bus_init_signal_cnt   = `SBAC_BUS_INIT_SIGNAL_PULSE;
            next_bus_init_signal_drive = 1'b1;
        end
        if (bus_init_signal_obs) begin
            // Only lock and arbitration reset; queues live elsewhere
            next_state       = sbac_pkg::SBAC_IDLE;
            next_lock_active = 1'b0;
        end else begin
            if (BUS_OWNER && TXN_LOCKED)
                next_lock_active = 1'b1;
            else if (!TXN_PENDING)
                next_lock_active = 1'b0;
            case (state)
                // Idle re-arbitrates whenever work is pending once config is valid
                sbac_pkg::SBAC_IDLE: begin
                    if (cfg_valid && TXN_PENDING)
                        next_state = sbac_pkg::SBAC_REQ;
                end
                sbac_pkg::SBAC_REQ: begin
                    if (!TXN_PENDING)
                        next_state = sbac_pkg::SBAC_IDLE;
                    else if (BUS_OWNER)
                        next_state = sbac_pkg::SBAC_OWN;
                end
                sbac_pkg::SBAC_OWN: begin
                    if (!TXN_PENDING || !BUS_OWNER)
                        next_state = sbac_pkg::SBAC_IDLE;
                end
                default: next_state = sbac_pkg::SBAC_IDLE;
            endcase
        end
    end

    // Register arbitration state
    always_ff @(posedge CORE_CLK or negedge NRST) begin
        if (!NRST) begin
            state       <= sbac_pkg::SBAC_IDLE;
            lock_active <= 1'b0;
            bus_init_signal_drive <= 1'b0;
            bus_init_signal_cnt   <= `SBAC_CNT_ZERO;
            bus_init_signal_seen  <= 1'b0;
            bnr_drive   <= 1'b0;
        end else begin
            state       <= next_state;
            lock_active <= next_lock_active;
            bus_init_signal_drive <= next_bus_init_signal_drive;
            bus_init_signal_cnt   <= next_bus_init_signal_cnt;
            bus_init_signal_seen  <= next_bus_init_signal_seen;
            bnr_drive   <= next_bnr_drive;
        end
    end

    //------------------------------------------------------------------
    // Debug and monitor pins
    //------------------------------------------------------------------

    // Monitor group: status low bits, probe ready on its pin
    always_comb begin
        next_bpm_out = '1;
        next_bpm_out[3:0] = ~MONITOR_STATUS;
        next_bpm_out[`SBAC_BPM_PROBE_READY] = ~DEBUG_READY;
        next_probe_request = !BREAKPOINT_MONITOR_PINS_N_IN[`SBAC_BPM_PROBE_REQUEST];
    end

    // Register monitor outputs and probe request
    always_ff @(posedge CORE_CLK or negedge NRST) begin
        if (!NRST) begin
            bpm_out <= '1;
            probe_request    <= 1'b0;
        end else begin
            bpm_out <= next_bpm_out;
            probe_request    <= next_probe_request;
        end
    end

    //------------------------------------------------------------------
    // Outputs
    //------------------------------------------------------------------

    // Open-drain style pins: enable only while pulling low
    assign BUS_INIT_SIGNAL_N_OUT           = 1'b0;
    assign BUS_INIT_SIGNAL_N_OE            = bus_init_signal_drive;
    assign BLOCK_NEXT_REQUEST_SIGNAL_N_OUT = 1'b0;
    assign BLOCK_NEXT_REQUEST_SIGNAL_N_OE  = bnr_drive;
    // Request held off until config done so the strap is readable
    assign BUS_REQUEST_OUT_N_OUT = !(state == sbac_pkg::SBAC_REQ || state == sbac_pkg::SBAC_OWN);
    assign BUS_REQUEST_OUT_N_OE  = cfg_valid;
    assign BREAKPOINT_MONITOR_PINS_N_OUT = bpm_out;
    // Probe request pin is input only, never driven
    assign BREAKPOINT_MONITOR_PINS_N_OE  = {1'b0, {(BPM_W-1){1'b1}}};

    // Issue gate: stall blocks all, priority blocks unless locked
    assign ISSUE_ALLOWED = (state == sbac_pkg::SBAC_OWN) && !stalled && !bus_init_signal_obs
                           && (!prio || lock_active);
    assign BUS_INIT_SEEN    = bus_init_signal_seen;
    assign PROBE_REQUEST    = probe_request;
    assign CFG_VALID        = cfg_valid;
    assign AGENT_ID         = cfg.agent_id;
    assign BUS_CLOCK_SELECT = cfg.bus_clock_select;

    //------------------------------------------------------------------
    // Checks
    //------------------------------------------------------------------

    property p_no_issue_stall;
        @(posedge CORE_CLK) disable iff (!NRST)
        stalled |-> !ISSUE_ALLOWED;
    endproperty
    a_no_issue_stall: assert property (p_no_issue_stall) else $error("issue during stall");

    property p_prio_block;
        @(posedge CORE_CLK) disable iff (!NRST)
        (prio && !lock_active) |-> !ISSUE_ALLOWED;
    endproperty
    a_prio_block: assert property (p_prio_block) else $error("issue under priority");

    property p_bnr;
        @(posedge CORE_CLK) disable iff (!NRST)
        CANNOT_ACCEPT |=> BLOCK_NEXT_REQUEST_SIGNAL_N_OE;
    endproperty
    a_bnr: assert property (p_bnr) else $error("stall not driven");

    sequence s_fatal;
        cfg_valid && cfg.bus_init_signal_drv_en && FATAL_BUS_ERROR && bus_init_signal_cnt == `SBAC_CNT_ZERO;
    endsequence
    property p_bus_init_signal_drive;
        @(posedge CORE_CLK) disable iff (!NRST)
        s_fatal |=> BUS_INIT_SIGNAL_N_OE [*3];
    endproperty
    a_bus_init_signal_drive: assert property (p_bus_init_signal_drive) else $error("bus init not driven");

    property p_bus_init_signal_nodrv;
        @(posedge CORE_CLK) disable iff (!NRST)
        (cfg_valid && !cfg.bus_init_signal_drv_en) |-> !BUS_INIT_SIGNAL_N_OE;
    endproperty
    a_bus_init_signal_nodrv: assert property (p_bus_init_signal_nodrv) else $error("bus init driven when off");

    property p_bus_init_signal_reset;
        @(posedge CORE_CLK) disable iff (!NRST)
        bus_init_signal_obs |=> state == sbac_pkg::SBAC_IDLE && !lock_active;
    endproperty
    a_bus_init_signal_reset: assert property (p_bus_init_signal_reset) else $error("arbitration not reset");

    property p_rearb;
        @(posedge CORE_CLK) disable iff (!NRST)
        (bus_init_signal_obs ##1 (!bus_init_signal_obs && TXN_PENDING)) |=> state == sbac_pkg::SBAC_REQ;
    endproperty
    a_rearb: assert property (p_rearb) else $error("no re-arbitration");

    property p_req_pin;
        @(posedge CORE_CLK) disable iff (!NRST)
        (state == sbac_pkg::SBAC_REQ) |-> !BUS_REQUEST_OUT_N_OUT && BUS_REQUEST_OUT_N_OE;
    endproperty
    a_req_pin: assert property (p_req_pin) else $error("request not driven");

    property p_probe_ready;
        @(posedge CORE_CLK) disable iff (!NRST)
        DEBUG_READY |=> !BREAKPOINT_MONITOR_PINS_N_OUT[`SBAC_BPM_PROBE_READY];
    endproperty
    a_probe_ready: assert property (p_probe_ready) else $error("probe ready wrong");

    property p_probe_request;
        @(posedge CORE_CLK) disable iff (!NRST)
        !BREAKPOINT_MONITOR_PINS_N_IN[`SBAC_BPM_PROBE_REQUEST] |=> PROBE_REQUEST;
    endproperty
    a_probe_request: assert property (p_probe_request) else $error("probe request missed");

endmodule
`default_nettype wire

//--- sbac_far_side.sv
// Far side of the bus: other agents, priority agent, debug tool
`timescale 1ns/1ps
`default_nettype none

module sbac_far_side (
    // Clock
    input  wire logic       clk,
    // Bench commands
    input  wire logic       init_cmd,
    input  wire logic       stall_cmd,
    input  wire logic       probe_cmd,
    input  wire logic       id_high,
    input  wire logic       prio_go,
    input  wire logic [3:0] prio_jobs,
    // Device pin drivers
    input  wire logic       init_out,
    input  wire logic       init_oe,
    input  wire logic       bnr_out,
    input  wire logic       bnr_oe,
    input  wire logic       br_out,
    input  wire logic       br_oe,
    input  wire logic [5:0] bpm_out,
    input  wire logic [5:0] bpm_oe,
    // Resolved wires
    output logic            init_n,
    output logic            bnr_n,
    output logic            priority_agent_request_n,
    output logic            br_n,
    output logic [5:0]      bpm_n
);
    logic [3:0] jobs_left = 4'h0;

    // Priority agent keeps its request until its last job ends
    always @(posedge clk) begin
        if (jobs_left != 4'h0) begin
            jobs_left <= jobs_left - 4'h1;
        end else if (prio_go) begin
            jobs_left <= prio_jobs;
        end
    end

    // Terminated wires: a released line reads high (br_n reads id_high), never the last value
    assign priority_agent_request_n = (jobs_left == 4'h0);
    assign init_n = ~((init_oe & ~init_out) | init_cmd);
    assign bnr_n  = ~((bnr_oe & ~bnr_out) | stall_cmd);
    assign br_n   = br_oe ? br_out : id_high; // Strap resistor while released
    assign bpm_n  = ~(bpm_oe & ~bpm_out) & {~probe_cmd, 5'h1f};
endmodule

`default_nettype wire

//--- tb.sv
// Self-checking bench for the arbitration control block
`timescale 1ns/1ps
`default_nettype none

module tb;
    logic       clk = 1'b0;
    logic       nrst = 1'b0;
    logic       drv = 1'b1, obs = 1'b1, fatal = 1'b0, cannot = 1'b0;
    logic       pending = 1'b0, locked = 1'b0, owner = 1'b0, dbg = 1'b0;
    logic [1:0] sel = 2'h0;
    logic [3:0] mon = 4'h0, prio_jobs = 4'h0;
    logic       init_cmd = 1'b0, stall_cmd = 1'b0, probe_cmd = 1'b0;
    logic       id_high = 1'b0, prio_go = 1'b0;
    logic       init_out, init_oe, bnr_out, bnr_oe, br_out, br_oe;
    logic       init_n, bnr_n, priority_agent_request_n, br_n, issue, seen, probe, cfg_valid;
    logic [5:0] bpm_out, bpm_oe, bpm_n;
    logic [1:0] agent_id, bsel;
    int         bad_count = 0;
    int         n_checks = 0;
    int         cycles = 0;

    // ------------------------------------------------------------
    // Design and far side
    // ------------------------------------------------------------
    sbac_arbiter u_dut (
        .CORE_CLK(clk), .NRST(nrst), .BUS_INIT_SIGNAL_DRV_STRAP(drv), .BUS_INIT_SIGNAL_OBS_STRAP(obs),
        .BUS_CLOCK_SELECT_STRAP(sel), .BUS_INIT_SIGNAL_N_IN(init_n),
        .BUS_INIT_SIGNAL_N_OUT(init_out), .BUS_INIT_SIGNAL_N_OE(init_oe),
        .BLOCK_NEXT_REQUEST_SIGNAL_N_IN(bnr_n), .BLOCK_NEXT_REQUEST_SIGNAL_N_OUT(bnr_out),
        .BLOCK_NEXT_REQUEST_SIGNAL_N_OE(bnr_oe), .PRIORITY_AGENT_REQUEST_N(priority_agent_request_n),
        .BUS_REQUEST_OUT_N_IN(br_n), .BUS_REQUEST_OUT_N_OUT(br_out),
        .BUS_REQUEST_OUT_N_OE(br_oe), .BREAKPOINT_MONITOR_PINS_N_IN(bpm_n),
        .BREAKPOINT_MONITOR_PINS_N_OUT(bpm_out), .BREAKPOINT_MONITOR_PINS_N_OE(bpm_oe),
        .FATAL_BUS_ERROR(fatal), .CANNOT_ACCEPT(cannot), .TXN_PENDING(pending),
        .TXN_LOCKED(locked), .BUS_OWNER(owner), .MONITOR_STATUS(mon), .DEBUG_READY(dbg),
        .ISSUE_ALLOWED(issue), .BUS_INIT_SEEN(seen), .PROBE_REQUEST(probe),
        .CFG_VALID(cfg_valid), .AGENT_ID(agent_id), .BUS_CLOCK_SELECT(bsel)
    );

    sbac_far_side u_far (
        .clk(clk), .init_cmd(init_cmd), .stall_cmd(stall_cmd), .probe_cmd(probe_cmd),
        .id_high(id_high), .prio_go(prio_go), .prio_jobs(prio_jobs),
        .init_out(init_out), .init_oe(init_oe), .bnr_out(bnr_out), .bnr_oe(bnr_oe),
        .br_out(br_out), .br_oe(br_oe), .bpm_out(bpm_out), .bpm_oe(bpm_oe),
        .init_n(init_n), .bnr_n(bnr_n), .priority_agent_request_n(priority_agent_request_n), .br_n(br_n), .bpm_n(bpm_n)
    );

    // Clock and hang guard; ceiling well above the fewer than 80 cycles used
    initial begin
        forever #4 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            bad_count++;
            conclude();
        end
    end

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask

    task automatic conclude();
        $display("checks=%0d mismatches=%0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // Reset for 4 cycles; straps are taken on the 4th edge after release
    task automatic do_reset(input logic d, input logic o, input logic h, input logic [1:0] s);
        nrst = 1'b0;
        drv = d;
        obs = o;
        id_high = h;
        sel = s;
        cyc(4);
        check({bpm_oe, init_oe, bnr_oe, br_oe}, {6'h1f, 3'h0});
        nrst = 1'b1;
        cyc(3);
        check(cfg_valid, 1'b0);
        cyc(1);
        check({cfg_valid, bsel, agent_id}, {1'b1, s, 1'b0, h});
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_config();
        drv = ~drv;
        obs = ~obs;
        sel = ~sel;
        id_high = ~id_high;
        cyc(3);
        check({bsel, agent_id, br_oe, br_n}, {2'h1, 2'h0, 2'h3});
        drv = 1'b1;
        obs = 1'b1;
    endtask

    task automatic t_request();
        pending = 1'b1;
        cyc(1);
        check({br_n, issue}, 2'h0);
        owner = 1'b1;
        cyc(1);
        check(issue, 1'b1);
    endtask

    task automatic t_stall();
        cannot = 1'b1;
        cyc(1);
        check({bnr_oe, bnr_out, bnr_n}, 3'h4);
        cannot = 1'b0;
        cyc(1);
        check(bnr_oe, 1'b0);
        stall_cmd = 1'b1;
        cyc(1);
        check(issue, 1'b0);
        stall_cmd = 1'b0;
        cyc(1);
        check(issue, 1'b1);
    endtask

    // Unlocked owner yields to the priority agent, locked owner keeps going
    task automatic t_priority();
        for (int lk = 0; lk < 2; lk++) begin
            locked = lk[0];
            cyc(1);
            prio_jobs = 4'h3;
            prio_go = 1'b1;
            cyc(1);
            prio_go = 1'b0;
            check({priority_agent_request_n, issue}, {1'b0, lk[0]});
            cyc(3);
            check({priority_agent_request_n, issue}, 2'h3);
        end
        pending = 1'b0;
        owner = 1'b0;
        locked = 1'b0;
        cyc(1);
        check(br_n, 1'b1);
    endtask

    task automatic t_fatal(input logic d);
        fatal = 1'b1;
        cyc(1);
        fatal = 1'b0;
        check({init_oe, init_n}, {d, ~d});
        cyc(2);
        check(init_oe, d);
        cyc(1);
        check(init_oe, 1'b0);
        cyc(2);
    endtask

    // Observed init drops the request, which is then raised again
    task automatic t_observe(input logic o);
        pending = 1'b1;
        cyc(1);
        check(br_n, 1'b0);
        init_cmd = 1'b1;
        cyc(1);
        init_cmd = 1'b0;
        check({seen, br_n}, {o, o});
        cyc(2);
        check(br_n, 1'b0);
        pending = 1'b0;
        cyc(1);
    endtask

    task automatic t_monitor();
        for (int i = 0; i < 16; i++) begin
            mon = i[3:0];
            dbg = i[0];
            cyc(1);
            check(bpm_n, {1'b1, ~i[0], ~i[3:0]});
        end
        probe_cmd = 1'b1;
        cyc(1);
        check({probe, bpm_n[5]}, 2'h2);
        probe_cmd = 1'b0;
        cyc(1);
        check(probe, 1'b0);
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        do_reset(1'b1, 1'b1, 1'b0, 2'h1);
        t_config();
        t_request();
        t_stall();
        t_priority();
        t_fatal(1'b1);
        t_observe(1'b1);
        t_monitor();
        do_reset(1'b0, 1'b0, 1'b1, 2'h3);
        t_fatal(1'b0);
        t_observe(1'b0);
        conclude();
    end
endmodule

`default_nettype wire
